// ===== common/admf_pkg.sv
// Constants, types and decoding shared by the result data modifier.
package admf_pkg;

  // Data path widths
  localparam int CONV_W = 12;
  localparam int RES_W = 16;
  localparam int FILT_W = 14;
  localparam int CTRL_W = 4;
  localparam int SEL_W = 2;
  localparam int IDX_W = 4;

  // Data modification mode codes
  localparam logic [1:0] SEL_REDUCE = 2'h0;
  localparam logic [1:0] SEL_FILTER = 2'h1;
  localparam logic [1:0] SEL_DIFF = 2'h2;

  // Result register numbers with special abilities
  localparam logic [3:0] IDX_BASE = 4'h0;
  localparam logic [3:0] IDX_FILT_LO = 4'h7;
  localparam logic [3:0] IDX_FILT_HI = 4'hF;

  // Control field codes
  localparam logic [3:0] CTRL_NO_REDUCE = 4'h0;
  localparam logic [3:0] CODE_IIR_A = 4'hE;
  localparam logic [3:0] CODE_IIR_B = 4'hF;

  // IIR forms as shifts: y = y - (y >> decay) + (x << gain), DC gain 4
  localparam logic [1:0] IIR_A_DECAY = 2'h1;
  localparam logic [1:0] IIR_A_GAIN = 2'h1;
  localparam logic [1:0] IIR_B_DECAY = 2'h2;
  localparam logic [1:0] IIR_B_GAIN = 2'h0;

  // Reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [13:0] HIST_RST = 14'h0000;

  typedef enum {MODE_REDUCE, MODE_FILTER, MODE_DIFF, MODE_PLAIN} admf_mode_t;

  // New conversion result from the converter core
  typedef struct packed {
    logic valid;
    logic [CONV_W-1:0] data;
  } admf_conv_t;

  // Result control register content
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [CTRL_W-1:0] ctrl;
  } admf_ctrl_t;

  // FIR coefficient triple
  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } admf_coef_t;

  // FIR coefficients per control code; IIR codes return zero
  function automatic admf_coef_t admf_fir_coef(input logic [3:0] code);
    admf_coef_t k;
    k = '0;
    case (code)
      4'h0: k = '{2'h2, 2'h1, 2'h0};
      4'h1: k = '{2'h1, 2'h2, 2'h0};
      4'h2: k = '{2'h2, 2'h0, 2'h1};
      4'h3: k = '{2'h1, 2'h1, 2'h1};
      4'h4: k = '{2'h1, 2'h0, 2'h2};
      4'h5: k = '{2'h3, 2'h1, 2'h0};
      4'h6: k = '{2'h2, 2'h2, 2'h0};
      4'h7: k = '{2'h1, 2'h3, 2'h0};
      4'h8: k = '{2'h3, 2'h0, 2'h1};
      4'h9: k = '{2'h2, 2'h1, 2'h1};
      4'hA: k = '{2'h1, 2'h2, 2'h1};
      4'hB: k = '{2'h2, 2'h0, 2'h2};
      4'hC: k = '{2'h1, 2'h1, 2'h2};
      4'hD: k = '{2'h1, 2'h0, 2'h3};
      default: k = '0;
    endcase
    return k;
  endfunction

  // Effective mode: a mode the register cannot offer falls back to plain
  function automatic admf_mode_t admf_decode(input logic [1:0] sel,
                                            input logic [3:0] idx);
    admf_mode_t m;
    m = MODE_PLAIN;
    case (sel)
      SEL_REDUCE: m = MODE_REDUCE;
      SEL_FILTER: m = (idx == IDX_FILT_LO || idx == IDX_FILT_HI) ?
                      MODE_FILTER : MODE_PLAIN;
      SEL_DIFF: m = (idx != IDX_BASE) ? MODE_DIFF : MODE_PLAIN;
      default: m = MODE_PLAIN;
    endcase
    return m;
  endfunction

endpackage

// ===== src/admf_filter.sv
// FIR and IIR filter core with its own sample history.
`timescale 1ns/1ps
module admf_filter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic shift,
  input wire logic [3:0] code,
  input wire logic [11:0] sample,
  output logic [13:0] filt_out
);

  logic [11:0] hist1_q;
  logic [11:0] hist1_d;
  logic [11:0] hist2_q;
  logic [11:0] hist2_d;
  logic [13:0] iir_q;
  logic [13:0] iir_d;
  admf_pkg::admf_coef_t coef;
  logic [15:0] fir_sum;
  logic [15:0] iir_sum;
  logic [1:0] decay;
  logic [1:0] gain;
  logic is_iir;

  // Filter arithmetic; 16-bit sums, results fit 14 bits at DC gain <= 4
  always_comb
  begin
    coef = admf_pkg::admf_fir_coef(code);
    is_iir = (code == admf_pkg::CODE_IIR_A) || (code == admf_pkg::CODE_IIR_B);
    decay = (code == admf_pkg::CODE_IIR_A) ? admf_pkg::IIR_A_DECAY
                                            : admf_pkg::IIR_B_DECAY;
    gain = (code == admf_pkg::CODE_IIR_A) ? admf_pkg::IIR_A_GAIN
                                           : admf_pkg::IIR_B_GAIN;
    // Newest times a, previous times b, oldest times c
    fir_sum = 16'({14'h0000, coef.a} * {4'h0, sample})
            + 16'({14'h0000, coef.b} * {4'h0, hist1_q})
            + 16'({14'h0000, coef.c} * {4'h0, hist2_q});
    // Leaky integrator, steady state 4 times the input
    iir_sum = {2'h0, iir_q} - 16'({2'h0, iir_q} >> decay)
            + 16'({4'h0, sample} << gain);
    filt_out = is_iir ? iir_sum[13:0] : fir_sum[13:0];
    hist1_d = hist1_q;
    hist2_d = hist2_q;
    iir_d = iir_q;
    // History restarts from zero; early outputs are settling
    if (clear)
    begin
      hist1_d = 12'h000;
      hist2_d = 12'h000;
      iir_d = admf_pkg::HIST_RST;
    end
    else if (shift)
    begin
      hist1_d = sample;
      hist2_d = hist1_q;
      iir_d = iir_sum[13:0];
    end
  end

  // History registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist1_q <= 12'h000;
      hist2_q <= 12'h000;
      iir_q <= admf_pkg::HIST_RST;
    end
    else
    begin
      hist1_q <= hist1_d;
      hist2_q <= hist2_d;
      iir_q <= iir_d;
    end
  end

endmodule

// ===== src/admf_result_slot.sv
// One result register with reduction, filtering and difference modes.
`timescale 1ns/1ps
module admf_result_slot (
  input wire logic clk_sys,
  input wire logic rst_n,
  input admf_pkg::admf_conv_t conv_in,
  input admf_pkg::admf_ctrl_t ctrl_in,
  input wire logic ctrl_write,
  input wire logic [3:0] reg_index,
  input wire logic [15:0] base_result,
  input wire logic read_strobe,
  output logic [15:0] result_reg,
  output logic result_valid_flag,
  output logic [3:0] reduction_counter,
  output logic result_event
);

  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic vf_q;
  logic vf_d;
  logic event_q;
  logic event_d;
  logic hist_clear;
  logic vf_set;
  logic [13:0] filt_val;
  logic [15:0] sample_ext;
  logic cfg_change;
  // Per-mode candidates, computed before the mode picks one
  logic [15:0] red_val;
  logic [3:0] red_cnt;
  logic [15:0] diff_val;
  admf_pkg::admf_mode_t mode;

  // Availability of a mode depends on the register number
  assign mode = admf_pkg::admf_decode(sel_q, reg_index);
  // Converter delivers unsigned 12-bit data, zero extended
  assign sample_ext = {4'h0, conv_in.data};

  admf_filter u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(hist_clear),
    .shift(conv_in.valid && !ctrl_write && mode == admf_pkg::MODE_FILTER),
    .code(ctrl_q),
    .sample(conv_in.data),
    .filt_out(filt_val)
  );

  // Control group: a write with new fields clears result, counter and filter history; the valid flag keeps its value
  always_comb
  begin
    sel_d = sel_q;
    ctrl_d = ctrl_q;
    cfg_change = 1'b0;
    if (ctrl_write)
    begin
      sel_d = ctrl_in.sel;
      ctrl_d = ctrl_in.ctrl;
      // Rewriting the same values leaves a running sequence alone
      cfg_change = (ctrl_in.sel != sel_q) || (ctrl_in.ctrl != ctrl_q);
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= admf_pkg::SEL_RST;
      ctrl_q <= admf_pkg::CTRL_RST;
    end
    else
    begin
      sel_q <= sel_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Candidate values per mode, picked by the result group below
  always_comb
  begin
    // Counter 0 opens a sequence; 0 again after n+1 results
    if (cnt_q == admf_pkg::CNT_RST)
    begin
      red_val = sample_ext;
      red_cnt = ctrl_q;
    end
    else
    begin
      red_val = result_q + sample_ext; // Plain sum, no divide
      red_cnt = cnt_q - 4'h1;
    end
    // Wraps modulo 2^16; negative differences read as two's complement
    diff_val = sample_ext - base_result;
  end

  // Result group: accumulator, counter and the filter history clear
  always_comb
  begin
    result_d = result_q;
    cnt_d = cnt_q;
    vf_set = 1'b0;
    hist_clear = 1'b0;
    // A control write wins over a result arriving in the same cycle
    if (ctrl_write)
    begin
      if (cfg_change)
      begin
        result_d = admf_pkg::RESULT_RST;
        cnt_d = admf_pkg::CNT_RST;
        hist_clear = 1'b1;
      end
    end
    // One conversion updates the register according to the mode
    else if (conv_in.valid)
    begin
      case (mode)
        admf_pkg::MODE_REDUCE:
        begin
          result_d = red_val;
          cnt_d = red_cnt;
          // Event only when the whole sequence is
          vf_set = (red_cnt == admf_pkg::CNT_RST);
        end
        admf_pkg::MODE_FILTER:
        begin
          // History was cleared on entry, so early values still settle
          result_d = {2'h0, filt_val};
          vf_set = 1'b1;
        end
        admf_pkg::MODE_DIFF:
        begin
          result_d = diff_val;
          vf_set = 1'b1;
        end
        default:
        begin
          // Mode not offered here: the result is stored as it came
          result_d = sample_ext;
          vf_set = 1'b1;
        end
      endcase
    end
  end

  // Result registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q <= admf_pkg::RESULT_RST;
      cnt_q <= admf_pkg::CNT_RST;
    end
    else
    begin
      result_q <= result_d;
      cnt_q <= cnt_d;
    end
  end

  // Flag group: set wins over clear; a read in a new sequence is late
  always_comb
  begin
    event_d = vf_set;
    // Only a read at counter 0 clears, so a late reader keeps the flag
    if (vf_set)
      vf_d = 1'b1;
    else if (read_strobe && cnt_q == admf_pkg::CNT_RST)
      vf_d = 1'b0;
    else
      vf_d = vf_q;
  end

  // Flag and event registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vf_q <= 1'b0;
      event_q <= 1'b0;
    end
    else
    begin
      vf_q <= vf_d;
      event_q <= event_d;
    end
  end

  // Reader must see flag 1 and counter 0 together
  assign result_reg = result_q;
  assign result_valid_flag = vf_q;
  assign reduction_counter = cnt_q;
  assign result_event = event_q;

endmodule

// ===== tb/admf_core_model.sv
// Converter core model: one 12-bit result per request, prompt or late.
`timescale 1ns/1ps
module admf_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [11:0] d,
  input wire logic [3:0] sl,
  output admf_pkg::admf_conv_t conv
);
  logic pend_q;
  logic [3:0] wait_q;
  // Idle data shows the inverse of its last value, never a stale copy
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      conv <= '0;
    end
    else
    begin
      if (go)
      begin
        pend_q <= 1'b1;
        wait_q <= sl;
      end
      else if (wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (pend_q)
        pend_q <= 1'b0;
      // One-cycle result pulse once the delay has run out
      if (!go && wait_q == 4'h0 && pend_q)
        conv <= '{1'b1, d};
      else
        conv <= '{1'b0, ~conv.data};
    end
endmodule

// ===== tb/admf_slot_properties.sv
// Port-level assertions for one result register slot.
`timescale 1ns/1ps
module admf_slot_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input admf_pkg::admf_conv_t conv_in,
  input admf_pkg::admf_ctrl_t ctrl_in,
  input wire logic ctrl_write,
  input wire logic [3:0] reg_index,
  input wire logic [15:0] base_result,
  input wire logic read_strobe,
  input wire logic [15:0] result_reg,
  input wire logic result_valid_flag,
  input wire logic [3:0] reduction_counter,
  input wire logic result_event
);
  admf_pkg::admf_ctrl_t cfg_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the stored fields; the design's copy is not visible here
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      cfg_q <= '{admf_pkg::SEL_RST, admf_pkg::CTRL_RST};
    else if (ctrl_write)
      cfg_q <= ctrl_in;
  sequence taken_s;
    conv_in.valid && !ctrl_write;
  endsequence
  evt_flag_a: assert property (result_event |->
    result_valid_flag && reduction_counter == 4'h0) else $error("bad event");
  no_cause_a: assert property (!(conv_in.valid && !ctrl_write) |=>
    !result_event) else $error("event without result");
  clear_a: assert property (ctrl_write && ctrl_in != cfg_q |=>
    result_reg == 16'h0000 && reduction_counter == 4'h0 && !result_event)
    else $error("write did not clear");
  read_clr_a: assert property (read_strobe && !ctrl_write &&
    reduction_counter == 4'h0 |=> result_valid_flag == result_event)
    else $error("read did not clear flag");
  late_read_a: assert property (read_strobe && !ctrl_write &&
    reduction_counter != 4'h0 && result_valid_flag |=> result_valid_flag)
    else $error("late read cleared flag");
  flag_fall_a: assert property ($fell(result_valid_flag) |->
    $past(read_strobe)) else $error("flag fell without read");
  diff_a: assert property (taken_s ##0
    cfg_q.sel == admf_pkg::SEL_DIFF && reg_index != 4'h0 |=>
    result_event && result_reg ==
    {4'h0, $past(conv_in.data)} - $past(base_result)) else $error("bad diff");
  filt_only_a: assert property (taken_s ##0
    cfg_q.sel == admf_pkg::SEL_FILTER && reg_index != 4'h7 &&
    reg_index != 4'hF |=> result_event &&
    result_reg == {4'h0, $past(conv_in.data)}) else $error("bad fallback");
  pass_a: assert property (taken_s ##0 cfg_q.sel == 2'h0 &&
    cfg_q.ctrl == 4'h0 |=> result_event &&
    result_reg == {4'h0, $past(conv_in.data)}) else $error("bad plain");
endmodule
bind admf_result_slot admf_slot_properties chk (.clk_sys, .rst_n, .conv_in,
  .ctrl_in, .ctrl_write, .reg_index, .base_result, .read_strobe,
  .result_reg, .result_valid_flag, .reduction_counter, .result_event);

// ===== tb/tb.sv
// Self-checking bench for one result register slot.
`timescale 1ns/1ps
module tb;
  localparam logic [5:0] FIRK [14] = '{6'h24, 6'h18, 6'h21, 6'h15, 6'h12,
    6'h34, 6'h28, 6'h1C, 6'h31, 6'h25, 6'h19, 6'h22, 6'h16, 6'h13};
  localparam logic [3:0] NRED [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
  localparam logic [5:0] FB [3] = '{6'h0D, 6'h02, 6'h3F};
  logic clk_sys = 1'b0, rst_n = 1'b0, ctrl_write = 1'b0, read_strobe = 1'b0;
  logic go = 1'b0, flag, evt;
  logic [11:0] d = 12'h000;
  logic [3:0] sl = 4'h0, idx = 4'hF, cnt;
  logic [15:0] base = 16'h0000, res;
  admf_pkg::admf_ctrl_t cfg = '0;
  admf_pkg::admf_conv_t conv;
  logic [15:0] expq [$];
  int err_count = 0, n_checks = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  admf_core_model mdl (.clk_sys, .rst_n, .go, .d, .sl, .conv);
  admf_result_slot dut (.clk_sys, .rst_n, .conv_in(conv), .ctrl_in(cfg),
    .ctrl_write, .reg_index(idx), .base_result(base), .read_strobe,
    .result_reg(res), .result_valid_flag(flag), .reduction_counter(cnt),
    .result_event(evt));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] s, input logic [3:0] c);
    @(posedge clk_sys);
    ctrl_write <= 1'b1;
    cfg <= '{s, c};
    @(posedge clk_sys);
    ctrl_write <= 1'b0;
  endtask
  // Returns at the edge where the core's result is taken
  task automatic send(input logic [11:0] x, input logic [3:0] s);
    @(posedge clk_sys);
    go <= 1'b1;
    d <= x;
    sl <= s;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (s + 2) @(posedge clk_sys);
  endtask
  task automatic rd;
    @(posedge clk_sys);
    read_strobe <= 1'b1;
    @(posedge clk_sys);
    read_strobe <= 1'b0;
    @(negedge clk_sys);
  endtask
  // Each result event takes the oldest note; an event with none fails
  always @(negedge clk_sys)
    if (evt === 1'b1)
    begin
      if (expq.size() == 0)
        chk("spare event", 16'h0000, 16'h0001);
      else
        chk("result", expq.pop_front(), res);
    end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    logic [15:0] s;
    logic [13:0] y;
    logic [11:0] x, h1, h2;
    logic [5:0] k;
    void'($urandom(32'hA3772E43));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("reset", 16'h0000, res);
    // Reduction sums n+1 results; odd ones arrive late
    foreach (NRED[i])
    begin
      wr(admf_pkg::SEL_REDUCE, NRED[i]);
      s = 16'h0000;
      for (int r = 0; r <= NRED[i]; r++)
      begin
        x = $urandom;
        s = s + x;
        if (r == NRED[i]) expq.push_back(s);
        send(x, r[0] ? 4'h2 : 4'h0);
      end
      $display("reduce %0d done", NRED[i]);
    end
    wr(admf_pkg::SEL_DIFF, 4'h0);
    repeat (4)
    begin
      x = $urandom;
      s = $urandom;
      base <= s;
      expq.push_back({4'h0, x} - s);
      send(x, 4'h0);
    end
    $display("difference done");
    // All filter codes; every write differs, so history starts clean
    for (int c = 0; c < 16; c++)
    begin
      wr(admf_pkg::SEL_FILTER, c[3:0]);
      {y, h1, h2} = '0;
      k = (c < 14) ? FIRK[c] : 6'h00;
      repeat (3)
      begin
        x = $urandom;
        if (c < 14)
          y = k[5:4] * x + k[3:2] * h1 + k[1:0] * h2;
        else if (c == 14)
          y = y - (y >> 1) + (x << 1);
        else
          y = y - (y >> 2) + x;
        h2 = h1;
        h1 = x;
        expq.push_back({2'h0, y});
        send(x, 4'h0);
      end
    end
    $display("filter done");
    foreach (FB[i])
    begin
      idx <= FB[i][5:2];
      wr(FB[i][1:0], 4'h0);
      x = $urandom;
      expq.push_back({4'h0, x});
      send(x, 4'h1);
    end
    // The lower filter slot must filter: code 5 triples a fresh result
    idx <= 4'h7;
    wr(admf_pkg::SEL_FILTER, 4'h5);
    x = $urandom;
    expq.push_back({4'h0, x} * 16'h0003);
    send(x, 4'h0);
    idx <= 4'hF;
    $display("fallback done");
    wr(admf_pkg::SEL_REDUCE, 4'h1);
    x = $urandom;
    s = x;
    send(x, 4'h0);
    x = $urandom;
    expq.push_back(s + x);
    send(x, 4'h0);
    @(negedge clk_sys);
    chk("flag", 16'h0001, flag);
    x = $urandom;
    s = x;
    send(x, 4'h0);
    @(negedge clk_sys);
    chk("counter", 16'h0001, cnt);
    rd;
    chk("late flag", 16'h0001, flag);
    x = $urandom;
    expq.push_back(s + x);
    send(x, 4'h0);
    rd;
    chk("read flag", 16'h0000, flag);
    $display("flag done");
    // A changing write meets a result: result dropped, state cleared
    fork
      send(12'h5A5, 4'h1);
      begin
        repeat (3) @(posedge clk_sys);
        wr(admf_pkg::SEL_REDUCE, 4'h3);
      end
    join
    @(negedge clk_sys);
    chk("cleared", 16'h0000, res);
    chk("cleared count", 16'h0000, cnt);
    chk("events left", 16'h0000, 16'(expq.size()));
    $display("clear done");
    tally_and_finish;
  end
endmodule
